// [common/flash_cmd_map.svh]
// Register offsets, field positions, reset values and constants of the flash command sequencer.
// Assumes inclusion by bare name ahead of a module that reads the APB byte address.
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_STATUS 12'h000
`define OFS_INDEX 12'h004
`define OFS_PARAM 12'h008
`define OFS_SECURITY 12'h00c
`define OFS_PROT 12'h010
`define OFS_MODE 12'h014
`define OFS_MARGIN 12'h018

// ****************************************************************
// Status field positions
// ****************************************************************
`define ST_DONE 7
`define ST_ACCESS_ERR 5
`define ST_PROT_VIOL 4
`define ST_MG1 1
`define ST_MG0 0

// ****************************************************************
// Security and protection fields
// ****************************************************************
`define SEC_SECURED 0
`define SEC_BDEN_LO 2
`define PROT_EN 31
`define PROT_EE 30

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_BDEN 2'h2
`define RST_MODE 4'hf
`define RST_PROT_BASE 24'hffffff

// ****************************************************************
// Opcodes, index values, margin levels
// ****************************************************************
`define OP_SECTOR_ERASE 8'h0a
`define OP_UNSECURE 8'h0b
`define OP_BACKDOOR 8'h0c
`define OP_USER_MARGIN 8'h0d
`define IDX_SECTOR 3'h1
`define IDX_UNSECURE 3'h0
`define IDX_BACKDOOR 3'h4
`define IDX_MARGIN 3'h2
`define BDEN_ON 2'h2
`define MARGIN_MAX 16'h0002

// ****************************************************************
// Address map
// ****************************************************************
`define PF_LO 24'hfc0000
`define PF_HI 24'hffffff
`define EE_LO 24'h100000
`define EE_HI 24'h1007ff
`define SECTOR_MASK 24'hfffe00
`define KEY_ADDR 24'hfffe00

`endif

// [common/flash_cmd_pkg.sv]
// Types shared by the flash command sequencer and its bench.
// Assumes nothing of its surroundings.
package flash_cmd_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CHECK = 2'h1,
        ST_ERASE = 2'h3,
        ST_KEY = 2'h2
    } seq_state_t;

    typedef struct packed {
        logic req;
        logic all;
        logic [23:0] addr;
    } flash_req_t;

    typedef struct packed {
        logic done;
        logic verifyErr;
        logic verifyFatal;
    } flash_rsp_t;

    typedef struct packed {
        seq_state_t state;
        logic cmdCompleteFlag;
        logic accessErrorFlag;
        logic protectionViolationFlag;
        logic verifyErrorFlag;
        logic verifyFatalErrorFlag;
        logic [2:0] paramSlotIndex;
        logic [4:0][15:0] cmdParamArray;
        logic secured;
        logic [1:0] backdoorEnableField;
        logic keyLocked;
        logic protEn;
        logic eeProt;
        logic [23:0] protBase;
        logic [3:0] modeAllow;
        logic [1:0] pfMargin;
        logic [1:0] eeMargin;
        flash_req_t flashReq;
        logic [31:0] prdata;
        logic pslverr;
    } seq_regs_t;

endpackage : flash_cmd_pkg

// [src/flash_cmd_seq.sv]
// Flash command sequencer: sector erase, unsecure, backdoor key, user margin.
// Assumes an APB master on clk, a flash array that answers erase requests with a done pulse,
// and the stored backdoor key presented on storedKey.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_map.svh"

// Operation
// - Erase, verify, then set complete
// - Sector erase index not 001: access error
// - Unaligned phrase address: access error
// - Protected sector: violation, no erase
// - Each verify error sets its own verify flag
// - Command disallowed in mode: access error
// - Invalid global address: access error
// - Unsecure erases all, releases on pass
// - Failed verify keeps security, sets flag
// - Unsecure index not 000: access error
// - Any protection: unsecure violation
// - Backdoor needs index 100: four keys
// - Backdoor enable field must be 10
// - All keys match: release security
// - Mismatch locks backdoor until reset
// - Margin command stores level, completes
// - Margin levels 0..2 only, else error
// - Flash margin applies to both blocks
module flash_cmd_seq
    import flash_cmd_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [63:0] storedKey,
    output flash_req_t flashReq,
    input wire flash_rsp_t flashRsp,
    output logic secured,
    output logic cmdCompleteFlag,
    output logic [1:0] pfReadMargin,
    output logic [1:0] eeReadMargin
);

    // ****************************************************************
    // State
    // ****************************************************************
    seq_regs_t r_q;
    seq_regs_t r_d;

    logic setup;
    logic wrAcc;
    logic mapped;
    logic [7:0] opcode;
    logic [23:0] gaddr;
    logic inPf;
    logic inEe;
    logic allowed;
    logic [63:0] keyIn;
    logic [31:0] rdMux;

    assign setup = psel && !penable;
    assign wrAcc = psel && penable && pwrite;
    assign opcode = r_q.cmdParamArray[0][15:8];
    assign gaddr = {r_q.cmdParamArray[0][7:0], r_q.cmdParamArray[1]};
    assign inPf = (gaddr >= `PF_LO) && (gaddr <= `PF_HI);
    assign inEe = (gaddr >= `EE_LO) && (gaddr <= `EE_HI);
    assign keyIn = {r_q.cmdParamArray[1], r_q.cmdParamArray[2], r_q.cmdParamArray[3], r_q.cmdParamArray[4]};

    // ****************************************************************
    // Mode permission per opcode
    // ****************************************************************
    always_comb begin
        case (opcode)
            `OP_SECTOR_ERASE: allowed = r_q.modeAllow[0];
            `OP_UNSECURE: allowed = r_q.modeAllow[1];
            `OP_BACKDOOR: allowed = r_q.modeAllow[2];
            `OP_USER_MARGIN: allowed = r_q.modeAllow[3];
            default: allowed = 1'b0;
        endcase
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always_comb begin
        rdMux = 32'h0;
        mapped = 1'b1;
        case (paddr)
            `OFS_STATUS: begin
                rdMux[`ST_DONE] = r_q.cmdCompleteFlag;
                rdMux[`ST_ACCESS_ERR] = r_q.accessErrorFlag;
                rdMux[`ST_PROT_VIOL] = r_q.protectionViolationFlag;
                rdMux[`ST_MG1] = r_q.verifyErrorFlag;
                rdMux[`ST_MG0] = r_q.verifyFatalErrorFlag;
            end
            `OFS_INDEX: rdMux[2:0] = r_q.paramSlotIndex;
            `OFS_PARAM: begin
                if (r_q.paramSlotIndex <= 3'h4) begin
                    rdMux[15:0] = r_q.cmdParamArray[r_q.paramSlotIndex];
                end
            end
            `OFS_SECURITY: begin
                rdMux[`SEC_SECURED] = r_q.secured;
                rdMux[`SEC_BDEN_LO +: 2] = r_q.backdoorEnableField;
            end
            `OFS_PROT: rdMux = {r_q.protEn, r_q.eeProt, 6'h0, r_q.protBase};
            `OFS_MODE: rdMux[3:0] = r_q.modeAllow;
            `OFS_MARGIN: rdMux[3:0] = {r_q.eeMargin, r_q.pfMargin};
            default: mapped = 1'b0;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        r_d = r_q;
        // APB read data and error captured in the setup cycle
        if (setup) begin
            r_d.prdata = pwrite ? 32'h0 : rdMux;
            r_d.pslverr = !mapped;
        end
        // Register writes
        if (wrAcc && mapped) begin
            case (paddr)
                `OFS_STATUS: begin
                    // Access error and protection violation flags clear by writing one
                    if (pwdata[`ST_ACCESS_ERR]) begin
                        r_d.accessErrorFlag = 1'b0;
                    end
                    if (pwdata[`ST_PROT_VIOL]) begin
                        r_d.protectionViolationFlag = 1'b0;
                    end
                    // Launch only from idle with no pending errors
                    if (pwdata[`ST_DONE] && r_q.cmdCompleteFlag && r_q.state == ST_IDLE
                            && !r_q.accessErrorFlag && !r_q.protectionViolationFlag) begin
                        r_d.cmdCompleteFlag = 1'b0;
                        r_d.verifyErrorFlag = 1'b0;
                        r_d.verifyFatalErrorFlag = 1'b0;
                        r_d.state = ST_CHECK;
                    end
                end
                `OFS_INDEX: begin
                    if (r_q.cmdCompleteFlag) begin
                        r_d.paramSlotIndex = pwdata[2:0];
                    end
                end
                `OFS_PARAM: begin
                    if (r_q.cmdCompleteFlag && r_q.paramSlotIndex <= 3'h4) begin
                        r_d.cmdParamArray[r_q.paramSlotIndex] = pwdata[15:0];
                    end
                end
                `OFS_SECURITY: begin
                    if (r_q.cmdCompleteFlag) begin
                        r_d.backdoorEnableField = pwdata[`SEC_BDEN_LO +: 2];
                    end
                end
                `OFS_PROT: begin
                    if (r_q.cmdCompleteFlag) begin
                        r_d.protEn = pwdata[`PROT_EN];
                        r_d.eeProt = pwdata[`PROT_EE];
                        r_d.protBase = pwdata[23:0];
                    end
                end
                `OFS_MODE: begin
                    if (r_q.cmdCompleteFlag) begin
                        r_d.modeAllow = pwdata[3:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // Command sequencer
        case (r_q.state)
            ST_IDLE: begin
            end
            ST_CHECK: begin
                r_d.state = ST_IDLE;
                r_d.cmdCompleteFlag = 1'b1;
                case (opcode)
                    `OP_SECTOR_ERASE: begin
                        if (r_q.paramSlotIndex != `IDX_SECTOR) begin
                            r_d.accessErrorFlag = 1'b1;
                        end else if (!allowed) begin
                            r_d.accessErrorFlag = 1'b1;
                        end else if (!inPf) begin
                            r_d.accessErrorFlag = 1'b1;
                        end else if (gaddr[2:0] != 3'h0) begin
                            r_d.accessErrorFlag = 1'b1;
                        end else if (r_q.protEn && ((gaddr & `SECTOR_MASK) >= (r_q.protBase & `SECTOR_MASK))) begin
                            r_d.protectionViolationFlag = 1'b1;
                        end else begin
                            r_d.cmdCompleteFlag = 1'b0;
                            r_d.state = ST_ERASE;
                            r_d.flashReq.req = 1'b1;
                            r_d.flashReq.all = 1'b0;
                            r_d.flashReq.addr = gaddr & `SECTOR_MASK;
                        end
                    end
                    `OP_UNSECURE: begin
                        if (r_q.paramSlotIndex != `IDX_UNSECURE || !allowed) begin
                            r_d.accessErrorFlag = 1'b1;
                        end else if (r_q.protEn || r_q.eeProt) begin
                            r_d.protectionViolationFlag = 1'b1;
                        end else begin
                            r_d.cmdCompleteFlag = 1'b0;
                            r_d.state = ST_ERASE;
                            r_d.flashReq.req = 1'b1;
                            r_d.flashReq.all = 1'b1;
                            r_d.flashReq.addr = 24'h0;
                        end
                    end
                    `OP_BACKDOOR: begin
                        if (r_q.paramSlotIndex != `IDX_BACKDOOR || !allowed) begin
                            r_d.accessErrorFlag = 1'b1;
                        end else if (r_q.backdoorEnableField != `BDEN_ON) begin
                            r_d.accessErrorFlag = 1'b1;
                        end else if (r_q.keyLocked) begin
                            r_d.accessErrorFlag = 1'b1;
                        end else begin
                            r_d.cmdCompleteFlag = 1'b0;
                            r_d.state = ST_KEY;
                        end
                    end
                    `OP_USER_MARGIN: begin
                        if (r_q.paramSlotIndex != `IDX_MARGIN || !allowed) begin
                            r_d.accessErrorFlag = 1'b1;
                        end else if (!inPf && !inEe) begin
                            r_d.accessErrorFlag = 1'b1;
                        end else if (r_q.cmdParamArray[2] > `MARGIN_MAX) begin
                            r_d.accessErrorFlag = 1'b1;
                        end else if (inPf) begin
                            r_d.pfMargin = r_q.cmdParamArray[2][1:0];
                            r_d.eeMargin = r_q.cmdParamArray[2][1:0];
                        end else begin
                            r_d.eeMargin = r_q.cmdParamArray[2][1:0];
                        end
                    end
                    default: r_d.accessErrorFlag = 1'b1;
                endcase
            end
            ST_ERASE: begin
                if (flashRsp.done) begin
                    r_d.flashReq.req = 1'b0;
                    r_d.verifyErrorFlag = flashRsp.verifyErr;
                    r_d.verifyFatalErrorFlag = flashRsp.verifyFatal;
                    if (r_q.flashReq.all && !flashRsp.verifyErr) begin
                        r_d.secured = 1'b0;
                    end
                    r_d.cmdCompleteFlag = 1'b1;
                    r_d.state = ST_IDLE;
                end
            end
            ST_KEY: begin
                // Key 0 is the word at the stored key base
                if (keyIn == storedKey) begin
                    r_d.secured = 1'b0;
                end else begin
                    r_d.accessErrorFlag = 1'b1;
                    r_d.keyLocked = 1'b1;
                end
                r_d.cmdCompleteFlag = 1'b1;
                r_d.state = ST_IDLE;
            end
            default: r_d.state = ST_IDLE;
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_q <= '0;
            r_q.state <= ST_IDLE;
            r_q.cmdCompleteFlag <= 1'b1;
            r_q.secured <= 1'b1;
            r_q.backdoorEnableField <= `RST_BDEN;
            r_q.modeAllow <= `RST_MODE;
            r_q.protBase <= `RST_PROT_BASE;
        end else begin
            r_q <= r_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata = r_q.prdata;
    assign pslverr = r_q.pslverr;
    assign pready = 1'b1;
    assign flashReq = r_q.flashReq;
    assign secured = r_q.secured;
    assign cmdCompleteFlag = r_q.cmdCompleteFlag;
    assign pfReadMargin = r_q.pfMargin;
    assign eeReadMargin = r_q.eeMargin;

endmodule : flash_cmd_seq
`default_nettype wire

// [test/flash_cmd_seq_sva.sv]
// Port checker of the flash command sequencer.
// Assumes a bind onto flash_cmd_seq, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_seq_sva
    import flash_cmd_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire flash_req_t flashReq,
    input wire flash_rsp_t flashRsp,
    input wire logic secured,
    input wire logic cmdCompleteFlag,
    input wire logic [1:0] pfReadMargin,
    input wire logic [1:0] eeReadMargin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_req_while_busy:
    assert property (flashReq.req |-> !cmdCompleteFlag) else $error("erase request while idle");
    a_req_after_check:
    assert property ($rose(flashReq.req) |-> !$past(cmdCompleteFlag)) else $error("erase before check");
    a_sector_base:
    assert property (flashReq.req && !flashReq.all |-> flashReq.addr[8:0] == 9'h000 && flashReq.addr >= 24'hfc0000)
        else $error("bad sector address");
    a_done_completes:
    assert property (flashReq.req && flashRsp.done |=> !flashReq.req && cmdCompleteFlag) else $error("no completion");
    a_unsec_pass:
    assert property (flashReq.req && flashReq.all && flashRsp.done && !flashRsp.verifyErr |=> !secured)
        else $error("security kept after good unsecure");
    a_unsec_fail:
    assert property (flashReq.req && flashReq.all && flashRsp.done && flashRsp.verifyErr |=> secured == $past(secured))
        else $error("security changed after failed unsecure");
    a_release_at_end:
    assert property ($fell(secured) |-> !$past(cmdCompleteFlag)) else $error("release outside command");
    a_margin_legal:
    assert property (pfReadMargin != 2'h3 && eeReadMargin != 2'h3) else $error("illegal margin");
    a_pf_sets_both:
    assert property ($changed(pfReadMargin) |-> eeReadMargin == pfReadMargin) else $error("margin not shared");
    a_margin_at_end:
    assert property ($changed(eeReadMargin) |-> !$past(cmdCompleteFlag)) else $error("margin change while idle");
    c_erase_done: cover property (flashReq.req && !flashReq.all && flashRsp.done);
    c_unsec_done: cover property (flashReq.req && flashReq.all && flashRsp.done);
    c_release: cover property ($fell(secured));
endmodule : flash_cmd_seq_sva
`default_nettype wire

// [test/flash_cmd_seq_tb.sv]
// Self-checking bench of the flash command sequencer.
// Assumes the map header, package and checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_map.svh"
module flash_cmd_seq_tb;
    import flash_cmd_pkg::*;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, reqSeen = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdData;
    logic pready, pslverr, secured, cmdCompleteFlag;
    logic [63:0] storedKey = 64'h1234_5678_9abc_def0;
    logic [2:0] idxTab [4] = '{3'h1, 3'h0, 3'h4, 3'h2};
    flash_req_t flashReq;
    flash_rsp_t flashRsp = '0;
    logic [1:0] pfReadMargin, eeReadMargin;
    int errTotal = 0, numChecks = 0, cycles = 0;
    always #2.5 clk = ~clk;
    flash_cmd_seq flash_cmd_seq_i (.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .storedKey(storedKey), .flashReq(flashReq), .flashRsp(flashRsp),
        .secured(secured), .cmdCompleteFlag(cmdCompleteFlag), .pfReadMargin(pfReadMargin),
        .eeReadMargin(eeReadMargin));
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (flashReq.req === 1'b1) reqSeen = 1'b1;
        if (cycles == 20000) begin
            errTotal++;
            finalReport();
        end
    end
    task automatic finalReport();
        $display("checks %0d errors %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finalReport
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdData = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic slot(input logic [2:0] i, input logic [15:0] v);
        apb(1'b1, `OFS_INDEX, {29'h0, i});
        apb(1'b1, `OFS_PARAM, {16'h0, v});
    endtask : slot
    task automatic go(input logic [2:0] idx);
        apb(1'b1, `OFS_INDEX, {29'h0, idx});
        reqSeen = 1'b0;
        apb(1'b1, `OFS_STATUS, 32'h80);
    endtask : go
    task automatic launch(input logic [7:0] op, input logic [23:0] a, input logic [15:0] lvl, input logic [2:0] idx);
        slot(3'h0, {op, a[23:16]});
        slot(3'h1, a[15:0]);
        slot(3'h2, lvl);
        go(idx);
    endtask : launch
    task automatic waitDone();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (cmdCompleteFlag !== 1'b1 && n < 100);
        chk("complete", cmdCompleteFlag, 1'b1);
    endtask : waitDone
    task automatic status(input logic [7:0] exp);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("status", rdData, {24'h0, exp});
        apb(1'b1, `OFS_STATUS, 32'h30);
    endtask : status
    task automatic errCase(input logic [7:0] op, input logic [23:0] a, input logic [15:0] lvl,
                           input logic [2:0] idx, input logic [7:0] exp);
        launch(op, a, lvl, idx);
        waitDone();
        chk("no erase", reqSeen, 1'b0);
        status(exp);
    endtask : errCase
    task automatic eraseRun(input logic [31:0] expReq, input logic err, input logic fatal);
        int n;
        n = 0;
        while (flashReq.req !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        chk("erase req", {7'h0, flashReq.all, flashReq.addr}, expReq);
        if (!expReq[24]) begin
            apb(1'b1, `OFS_STATUS, 32'h80);
            chk("busy", flashReq.req, 1'b1);
        end
        flashRsp <= '{1'b1, err, fatal};
        @(posedge clk);
        flashRsp <= '0;
        waitDone();
    endtask : eraseRun
    task automatic backdoor(input logic [63:0] k);
        slot(3'h0, {`OP_BACKDOOR, 8'h00});
        for (int i = 0; i < 4; i++) slot(3'(i + 1), k[63 - 16 * i -: 16]);
        go(`IDX_BACKDOOR);
        waitDone();
    endtask : backdoor
    task automatic doReset();
        @(posedge clk);
        sysRst <= 1'b1;
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
    endtask : doReset
    task automatic resetVals();
        status(8'h80);
        apb(1'b0, `OFS_SECURITY, 32'h0);
        chk("security", rdData, 32'h9);
        apb(1'b0, 12'h01c, 32'h0);
        chk("slverr", pslverr, 1'b1);
        chk("ready", pready, 1'b1);
        chk("margins", {pfReadMargin, eeReadMargin}, 4'h0);
    endtask : resetVals
    task automatic sectorErase();
        launch(`OP_SECTOR_ERASE, 24'hfc1238, 16'h0, `IDX_SECTOR);
        eraseRun(32'h00fc1200, 1'b1, 1'b1);
        status(8'h83);
    endtask : sectorErase
    task automatic errCases();
        errCase(`OP_SECTOR_ERASE, 24'hfc1238, 16'h0, 3'h2, 8'ha0);
        errCase(`OP_SECTOR_ERASE, 24'hfc1239, 16'h0, `IDX_SECTOR, 8'ha0);
        errCase(`OP_SECTOR_ERASE, 24'h002000, 16'h0, `IDX_SECTOR, 8'ha0);
        errCase(`OP_UNSECURE, 24'h0, 16'h0, 3'h1, 8'ha0);
        errCase(`OP_BACKDOOR, 24'h0, 16'h0, 3'h3, 8'ha0);
        errCase(`OP_USER_MARGIN, 24'h100000, 16'h0003, `IDX_MARGIN, 8'ha0);
        errCase(`OP_USER_MARGIN, 24'h300000, 16'h0001, `IDX_MARGIN, 8'ha0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `OFS_MODE, 32'hf ^ (32'h1 << i));
            errCase(8'h0a + 8'(i), 24'hfc1238, 16'h0001, idxTab[i], 8'ha0);
        end
        apb(1'b1, `OFS_MODE, 32'hf);
        apb(1'b1, `OFS_PROT, 32'h80fc1000);
        errCase(`OP_SECTOR_ERASE, 24'hfc1238, 16'h0, `IDX_SECTOR, 8'h90);
        errCase(`OP_UNSECURE, 24'h0, 16'h0, `IDX_UNSECURE, 8'h90);
        launch(`OP_SECTOR_ERASE, 24'hfc0808, 16'h0, `IDX_SECTOR);
        eraseRun(32'h00fc0800, 1'b0, 1'b0);
        status(8'h80);
        apb(1'b1, `OFS_PROT, 32'h40ffffff);
        errCase(`OP_UNSECURE, 24'h0, 16'h0, `IDX_UNSECURE, 8'h90);
        apb(1'b1, `OFS_PROT, 32'h00ffffff);
    endtask : errCases
    task automatic marginCmds();
        launch(`OP_USER_MARGIN, 24'h100000, 16'h0001, `IDX_MARGIN);
        waitDone();
        chk("ee margin", {pfReadMargin, eeReadMargin}, 4'h1);
        launch(`OP_USER_MARGIN, 24'hfc0000, 16'h0002, `IDX_MARGIN);
        waitDone();
        chk("pf margin", {pfReadMargin, eeReadMargin}, 4'ha);
        launch(`OP_USER_MARGIN, 24'h100000, 16'h0000, `IDX_MARGIN);
        waitDone();
        chk("normal", {pfReadMargin, eeReadMargin}, 4'h8);
        apb(1'b0, `OFS_MARGIN, 32'h0);
        chk("margin reg", rdData, 32'h2);
        status(8'h80);
    endtask : marginCmds
    task automatic unsecureCmd();
        launch(`OP_UNSECURE, 24'h0, 16'h0, `IDX_UNSECURE);
        eraseRun(32'h01000000, 1'b1, 1'b0);
        chk("kept", secured, 1'b1);
        status(8'h82);
        launch(`OP_UNSECURE, 24'h0, 16'h0, `IDX_UNSECURE);
        eraseRun(32'h01000000, 1'b0, 1'b1);
        chk("released", secured, 1'b0);
        status(8'h81);
    endtask : unsecureCmd
    task automatic backdoorCmd();
        doReset();
        apb(1'b1, `OFS_SECURITY, 32'h4);
        backdoor(storedKey);
        status(8'ha0);
        apb(1'b1, `OFS_SECURITY, 32'h8);
        backdoor({storedKey[63:16], ~storedKey[15:0]});
        chk("mismatch", secured, 1'b1);
        status(8'ha0);
        backdoor(storedKey);
        chk("locked", secured, 1'b1);
        status(8'ha0);
        doReset();
        backdoor(storedKey);
        chk("match", secured, 1'b0);
        status(8'h80);
    endtask : backdoorCmd
    initial begin
        repeat (12) @(posedge clk);
        sysRst <= 1'b0;
        resetVals();
        sectorErase();
        errCases();
        marginCmds();
        unsecureCmd();
        backdoorCmd();
        finalReport();
    end
endmodule : flash_cmd_seq_tb
bind flash_cmd_seq flash_cmd_seq_sva flash_cmd_seq_sva_i (.clk(clk), .sys_rst(sys_rst), .flashReq(flashReq),
    .flashRsp(flashRsp), .secured(secured), .cmdCompleteFlag(cmdCompleteFlag),
    .pfReadMargin(pfReadMargin), .eeReadMargin(eeReadMargin));
`default_nettype wire
